// >>> core/rai_params.svh
`ifndef RAI_PARAMS_SVH
`define RAI_PARAMS_SVH

// ---------------------------------------------
// register offsets
// ---------------------------------------------
`define RAI_ADR_CFG      6'h05
`define RAI_ADR_RX_EN    6'h07
`define RAI_ADR_RX_ST    6'h08
`define RAI_ADR_TX_EN    6'h0d
`define RAI_ADR_TX_ST    6'h0e
`define RAI_ADR_WK_EN    6'h1c
`define RAI_ADR_WK_ST    6'h1d
`define RAI_ADR_TX_CLR   6'h3a
`define RAI_ADR_RX_CLR   6'h3b

// ---------------------------------------------
// field positions
// ---------------------------------------------
`define RAI_CFG_POL_BIT  0
`define RAI_CFG_OPEN_BIT 1
`define RAI_WK_BIT       0
`define RAI_RX_A_LSB     0
`define RAI_RX_B_LSB     4

// ---------------------------------------------
// reset values
// ---------------------------------------------
`define RAI_CFG_RST      8'h01
`define RAI_EN_RST       8'h00
`define RAI_ST_RST       8'h00
`define RAI_WK_ST_RST    8'h01

// ---------------------------------------------
// timing
// ---------------------------------------------
`define RAI_CLK_HZ       10000000
`define RAI_OSC_START_NS 1000
`define RAI_OSC_CYC      ((`RAI_OSC_START_NS * (`RAI_CLK_HZ / 1000000) + 999) / 1000)

`endif

// >>> core/rai_pkg.sv
`default_nettype none
package rai_pkg;

  typedef enum logic [1:0] {
    RAI_OSC_OFF   = 2'b00,
    RAI_OSC_START = 2'b01,
    RAI_OSC_RUN   = 2'b10
  } rai_osc_e;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rx_en;
    logic [7:0] rx_st;
    logic [7:0] tx_en;
    logic [7:0] tx_st;
    logic [7:0] wk_en;
    logic [7:0] wk_st;
    logic [7:0] rdata;
    logic       irq;
    logic       irq_oe;
    logic       osc_run;
    logic       ready;
    logic       wake_evt;
    rai_osc_e   osc;
    logic [7:0] cnt;
  } rai_state_s;

endpackage : rai_pkg
`default_nettype wire

// >>> core/rai_top.sv
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "rai_params.svh"

// Contract
// R1: three groups, each separately enabled, share one interrupt output.
// R2: in transmit mode receive events never reach the interrupt output.
// R3: mode changes leave every enable register value untouched.
// R4: six interrupt registers at 0x07, 0x08, 0x0d, 0x0e, 0x1c, 0x1d.
// R5: status bits capture events regardless of their enable bits.
// R6: interrupt output polarity chosen by a bit of register 0x05.
// R7: output is open drain when active low, open source when high.
// R8: oscillator held stopped while power-down input is low.
// R9: host waits for wake event before register transfers.
// R10: wake event raised once the oscillator has started.
// R11: bit 0 of 0x1c enables wake; bit 0 of 0x1d shows it pending.
// R12: reading wake status clears the pending wake event.
// R13: four transmit events, enabled at 0x0d, status at 0x0e.
// R14: eight receive events, four per deserializer, at 0x07 and 0x08.
// R15: in double-rate modes deserializer B events never fire.
// R16: host reads status to find which event raised the interrupt.
// R17: output active while any enabled, unsuppressed status bit is set.
// R18: host drives bypass lines in transmit bypass mode.
module rai_top
  import rai_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  // register port
  input  wire logic [5:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output var  logic [7:0] reg_rdata_o,
  // event sources and radio mode
  input  wire logic [3:0] tx_evt_i,
  input  wire logic [7:0] rx_evt_i,
  input  wire logic       tx_mode_i,
  input  wire logic       ddr_mode_i,
  // power control
  input  wire logic       power_down_input_n_i,
  output var  logic       osc_run_o,
  output var  logic       ready_o,
  // interrupt pin
  output var  logic       irq_o,
  output var  logic       irq_oe_o
);

  // ---------------------------------------------
  // constants
  // ---------------------------------------------
  localparam logic [7:0] OSC_CYC = 8'(`RAI_OSC_CYC);
  localparam logic [7:0] WK_MASK = 8'h01 << `RAI_WK_BIT;

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  rai_state_s st;
  rai_state_s next_st;

  logic [7:0] rx_set;
  logic [7:0] tx_set;
  logic [7:0] rx_clr;
  logic [7:0] tx_clr;
  logic [7:0] wk_clr;
  logic [7:0] wk_set;
  logic       pend;
  logic       hi_act;
  logic       open_mode;
  logic [7:0] rx_evt_ok;
  logic [7:0] rx_hit;
  logic [7:0] tx_hit;

  // ---------------------------------------------
  // per-bit event gating
  // ---------------------------------------------
  // each bit is gated on its own so a masked source never leaks
  // into a neighbour through a shared reduction
  for (genvar gi = 0; gi < 8; gi++)
  begin : g_bit
    // deserializer b occupies the upper nibble
    localparam bit IS_B = (gi >= `RAI_RX_B_LSB);

    // in double-rate mode b events dropped at the input, so status never records them
    assign rx_evt_ok[gi] = rx_evt_i[gi] & ~(ddr_mode_i & IS_B); // see R15

    // mode gates only the effect; the stored enable is untouched
    assign rx_hit[gi] = &{st.rx_st[gi], st.rx_en[gi], ~tx_mode_i}; // see R2, R3

    assign tx_hit[gi] = st.tx_st[gi] & st.tx_en[gi]; // see R13
  end : g_bit

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb
  begin
    next_st = st;
    rx_set  = rx_evt_ok; // see R15
    tx_set  = {4'h0, tx_evt_i};
    rx_clr  = 8'h00;
    tx_clr  = 8'h00;
    wk_clr  = 8'h00;
    wk_set  = 8'h00;
    next_st.wake_evt = 1'b0;

    // -------------------------------------------
    // oscillator control
    // -------------------------------------------
    // a power-down at any point aborts the start and restarts the count
    case (st.osc)
      RAI_OSC_OFF:
      begin
        next_st.osc_run = 1'b0;
        next_st.ready   = 1'b0;
        next_st.cnt     = 8'h00;
        if (power_down_input_n_i)
        begin
          next_st.osc     = RAI_OSC_START; // see R8
          next_st.osc_run = 1'b1;
        end
      end
      RAI_OSC_START:
      begin
        if (!power_down_input_n_i)
        begin
          next_st.osc     = RAI_OSC_OFF; // see R8
          next_st.osc_run = 1'b0;
        end
        else if (st.cnt >= OSC_CYC - 8'h01)
        begin
          next_st.osc      = RAI_OSC_RUN;
          next_st.ready    = 1'b1;
          next_st.wake_evt = 1'b1; // see R10
        end
        else
        begin
          next_st.cnt = st.cnt + 8'h01;
        end
      end
      RAI_OSC_RUN:
      begin
        if (!power_down_input_n_i)
        begin
          next_st.osc     = RAI_OSC_OFF; // see R8
          next_st.osc_run = 1'b0;
          next_st.ready   = 1'b0;
        end
      end
      default:
      begin
        next_st.osc     = RAI_OSC_OFF;
        next_st.osc_run = 1'b0;
        next_st.ready   = 1'b0;
      end
    endcase

    if (st.wake_evt)
    begin
      wk_set = WK_MASK; // see R10
    end

    // -------------------------------------------
    // register writes
    // -------------------------------------------
    // status registers are not writable; a write there is dropped
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        `RAI_ADR_CFG:
        begin
          next_st.cfg = reg_wdata_i; // see R6
        end
        `RAI_ADR_RX_EN:
        begin
          next_st.rx_en = reg_wdata_i; // see R14
        end
        `RAI_ADR_TX_EN:
        begin
          next_st.tx_en = reg_wdata_i; // see R13
        end
        `RAI_ADR_WK_EN:
        begin
          next_st.wk_en = reg_wdata_i; // see R11
        end
        `RAI_ADR_TX_CLR:
        begin
          tx_clr = reg_wdata_i;
        end
        `RAI_ADR_RX_CLR:
        begin
          rx_clr = reg_wdata_i;
        end
        default:
        begin
          next_st.cfg = st.cfg;
        end
      endcase
    end

    // -------------------------------------------
    // register reads
    // -------------------------------------------
    // data one cycle later, zero otherwise so idle reads are clean
    next_st.rdata = 8'h00;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `RAI_ADR_CFG:
        begin
          next_st.rdata = st.cfg;
        end
        `RAI_ADR_RX_EN:
        begin
          next_st.rdata = st.rx_en;
        end
        `RAI_ADR_RX_ST:
        begin
          next_st.rdata = st.rx_st; // see R4
        end
        `RAI_ADR_TX_EN:
        begin
          next_st.rdata = st.tx_en;
        end
        `RAI_ADR_TX_ST:
        begin
          next_st.rdata = st.tx_st; // see R4
        end
        `RAI_ADR_WK_EN:
        begin
          next_st.rdata = st.wk_en;
        end
        `RAI_ADR_WK_ST:
        begin
          next_st.rdata = st.wk_st;
          wk_clr        = WK_MASK; // see R12
        end
        default:
        begin
          next_st.rdata = 8'h00;
        end
      endcase
    end

    // sticky status: a set in the same cycle beats a clear
    next_st.rx_st = (st.rx_st & ~rx_clr) | rx_set; // see R5
    next_st.tx_st = (st.tx_st & ~tx_clr) | tx_set; // see R5
    next_st.wk_st = ((st.wk_st & ~wk_clr) | wk_set) & WK_MASK; // see R11

    // -------------------------------------------
    // interrupt pin
    // -------------------------------------------
    // one pending term per group, then a single shared pin
    pend = (|rx_hit)
         | (|tx_hit)
         | (|(st.wk_st & st.wk_en & WK_MASK)); // see R1, R17

    hi_act    = st.cfg[`RAI_CFG_POL_BIT];
    open_mode = st.cfg[`RAI_CFG_OPEN_BIT];

    // pin level and drive
    next_st.irq = hi_act ? pend : ~pend; // see R6
    if (open_mode)
    begin
      // drives only the asserted level, pull resistor does the rest
      next_st.irq_oe = pend; // see R7
    end
    else
    begin
      next_st.irq_oe = 1'b1;
    end
  end

  // ---------------------------------------------
  // state register
  // ---------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st          <= '0;
      st.cfg      <= `RAI_CFG_RST;
      st.rx_en    <= `RAI_EN_RST;
      st.rx_st    <= `RAI_ST_RST;
      st.tx_en    <= `RAI_EN_RST;
      st.tx_st    <= `RAI_ST_RST;
      st.wk_en    <= `RAI_EN_RST;
      st.wk_st    <= `RAI_WK_ST_RST;
      st.irq      <= 1'b0;
      st.irq_oe   <= 1'b0;
      st.osc      <= RAI_OSC_OFF;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign reg_rdata_o = st.rdata;
  assign irq_o       = st.irq;
  assign irq_oe_o    = st.irq_oe;
  assign osc_run_o   = st.osc_run;
  assign ready_o     = st.ready;

endmodule : rai_top

`default_nettype wire

// >>> core/unused_placeholder_removed.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> sim/rai_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rai_top_asserts (
  input wire logic       ref_clk_i,
  input wire logic       sys_rst_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       power_down_input_n_i,
  input wire logic       osc_run_o,
  input wire logic       ready_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_osc_up;
    $rose(osc_run_o);
  endsequence
  // settled wake: set pulse long past, so a repeated read must see it gone
  sequence s_rd_wake;
    reg_rd_i && reg_addr_i == 6'h1d && $past(ready_o, 4);
  endsequence
  a_rdata_idle: assert property (
    !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_pd_stops_osc: assert property (
    !power_down_input_n_i |=> !osc_run_o && !ready_o)
    else $error("oscillator running while powered down");
  a_ready_bound: assert property (
    s_osc_up |-> ##[1:14] (ready_o || !osc_run_o))
    else $error("ready late after oscillator start");
  a_ready_late: assert property (
    $rose(ready_o) |-> $past(osc_run_o, 8))
    else $error("ready before oscillator settled");
  a_tx_upper_zero: assert property (
    reg_rd_i && reg_addr_i == 6'h0e |=> reg_rdata_o[7:4] == 4'h0)
    else $error("transmit status upper bits set");
  a_unmapped_zero: assert property (
    reg_rd_i && reg_addr_i == 6'h3f |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_wake_read_clr: assert property (
    s_rd_wake ##2 s_rd_wake |=> reg_rdata_o[0] == 1'b0)
    else $error("wake status not cleared by read");
  a_osc_needs_pd: assert property (
    $rose(osc_run_o) |-> $past(power_down_input_n_i))
    else $error("oscillator started without power-down release");
endmodule : rai_top_asserts
`default_nettype wire

// >>> sim/rai_mcu.sv
`timescale 1ns/1ps
`default_nettype none
module rai_mcu (
  input  wire logic clk_i,
  input  wire logic pd_req_i,
  input  wire logic irq_o,
  input  wire logic irq_oe_o,
  output var  logic power_down_input_n_o,
  output var  logic pin_o
);
  logic last = 1'b0;
  logic pin_q = 1'b0;
  // bypass lines move on the pin's rise, so they are settled at its fall
  logic bypass_data_line = 1'b0;
  logic bypass_data_valid_line = 1'b0;
  always @(posedge clk_i) pin_q <= pin_o;
  always @(posedge clk_i) if (pin_o && !pin_q) begin
    bypass_data_line <= ~bypass_data_line;
    bypass_data_valid_line <= 1'b1;
  end
  always @(posedge clk_i) power_down_input_n_o <= pd_req_i;
  always @(posedge clk_i) if (irq_oe_o) last <= irq_o;
  // released pin: no known pull, so show the inverse of the last level
  assign pin_o = irq_oe_o ? irq_o : ~last;
endmodule : rai_mcu
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module testbench;
  logic       ref_clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0, tx_mode_i = 1'b0, ddr_mode_i = 1'b0;
  logic [5:0] reg_addr_i = 6'h00;
  logic [7:0] reg_wdata_i = 8'h00, rx_evt_i = 8'h00, reg_rdata_o, cf = 8'h01;
  logic [3:0] tx_evt_i = 4'h0, t;
  logic       pd_n, osc_run_o, ready_o, irq_o, irq_oe_o, pin, pd_req = 1'b0;
  int         fails = 0, compares = 0, cyc = 0;
  rai_top dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .tx_evt_i(tx_evt_i), .rx_evt_i(rx_evt_i), .tx_mode_i(tx_mode_i),
    .ddr_mode_i(ddr_mode_i), .power_down_input_n_i(pd_n),
    .osc_run_o(osc_run_o), .ready_o(ready_o), .irq_o(irq_o),
    .irq_oe_o(irq_oe_o));
  rai_mcu mcu (.clk_i(ref_clk_i), .pd_req_i(pd_req), .irq_o(irq_o),
    .irq_oe_o(irq_oe_o), .power_down_input_n_o(pd_n), .pin_o(pin));
  initial forever #50 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (++cyc == 5000) begin fails++; end_of_test; end
  function automatic logic lvl(input logic pol, input logic act);
    return act ? pol : ~pol;
  endfunction : lvl
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 `CHK($sformatf("reg %h", a), e, reg_rdata_o)
    @(posedge ref_clk_i);
  endtask : rd
  task automatic pulse(input logic [3:0] tx, input logic [7:0] rx);
    tx_evt_i <= tx;
    rx_evt_i <= rx;
    @(posedge ref_clk_i);
    tx_evt_i <= 4'h0;
    rx_evt_i <= 8'h00;
  endtask : pulse
  task automatic chk(input logic act);
    repeat (3) @(posedge ref_clk_i);
    #1 `CHK("oe", cf[1] ? act : 1'b1, irq_oe_o)
    if (act || !cf[1]) `CHK("pin", lvl(cf[0], act), pin)
  endtask : chk
  // host holds off the register port until ready
  task automatic up();
    pd_req <= 1'b1;
    for (int i = 0; i < 40 && ready_o !== 1'b1; i++) @(posedge ref_clk_i);
    `CHK("ready", 1'b1, ready_o)
    repeat (3) @(posedge ref_clk_i);
  endtask : up
  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    void'($urandom(32'h5834));
    repeat (10) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    up();
    rd(6'h05, 8'h01);
    rd(6'h07, 8'h00);
    rd(6'h0d, 8'h00);
    rd(6'h1c, 8'h00);
    rd(6'h1d, 8'h01);
    rd(6'h1d, 8'h00);
    wr(6'h08, 8'hff);
    rd(6'h08, 8'h00);
    rd(6'h3f, 8'h00);
    $display("registers done");
    wr(6'h1c, 8'h01);
    pd_req <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    `CHK("osc", 1'b0, osc_run_o)
    up();
    chk(1'b1);
    rd(6'h1d, 8'h01);
    chk(1'b0);
    $display("wake done");
    for (int i = 0; i < 4; i++) begin
      t = 4'($urandom);
      pulse(t, 8'h00);
      rd(6'h0e, {4'h0, t});
      chk(1'b0);
      wr(6'h0d, {4'h0, t});
      chk(|t);
      wr(6'h3a, 8'hff);
      wr(6'h0d, 8'h00);
    end
    $display("transmit done");
    wr(6'h07, 8'hff);
    tx_mode_i <= 1'b1;
    pulse(4'h0, 8'h01);
    chk(1'b0);
    tx_mode_i <= 1'b0;
    chk(1'b1);
    rd(6'h07, 8'hff);
    wr(6'h3b, 8'hff);
    ddr_mode_i <= 1'b1;
    pulse(4'h0, 8'hf0);
    rd(6'h08, 8'h00);
    ddr_mode_i <= 1'b0;
    pulse(4'h0, 8'hf0);
    rd(6'h08, 8'hf0);
    wr(6'h3b, 8'hff);
    $display("receive done");
    wr(6'h0d, 8'h01);
    foreach (cf[i]) if (i < 3) begin
      cf = (i == 0) ? 8'h00 : 8'(i + 1);
      wr(6'h05, cf);
      chk(1'b0);
      pulse(4'h1, 8'h00);
      chk(1'b1);
      wr(6'h3a, 8'hff);
    end
    $display("polarity done");
    end_of_test;
  end
endmodule : testbench
bind rai_top rai_top_asserts chk_u (.ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .power_down_input_n_i(power_down_input_n_i),
  .osc_run_o(osc_run_o), .ready_o(ready_o));
`default_nettype wire
